// >>> src/ufbp_buf.sv
`timescale 1ns/100ps

// ---------------------------------------------------------------------
// small circular buffer, head word held in a register
// ---------------------------------------------------------------------
module ufbp_buf #(
  parameter int WIDTH = ufbp_pkg::BUS_W,     // word width
  parameter int DEPTH = ufbp_pkg::BUF_DEPTH  // number of entries
) (
  input  wire logic             clock,      // module clock
  input  wire logic             sys_rst,    // synchronous reset, high
  input  wire logic [WIDTH-1:0] in_data,    // word to store
  input  wire logic             in_valid,   // word offered
  output logic                  in_ready,   // room for a word
  output logic      [WIDTH-1:0] out_data,   // oldest word
  output logic                  out_valid,  // oldest word present
  input  wire logic             out_ready   // oldest word taken
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [CW-1:0]               cnt;
    logic [WIDTH-1:0]            head;
    logic                        vld;
    logic                        rdy;
  } ufbp_buf_s;

  ufbp_buf_s r;
  ufbp_buf_s n;
  logic      push;
  logic      pop;

  // wrap a pointer at the last entry
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // next state; head, valid and ready are recomputed so they leave flops
  always_comb begin
    n    = r;
    push = in_valid & r.rdy;
    pop  = out_ready & r.vld;
    if (push) begin
      n.mem[r.wr] = in_data;
      n.wr        = ptr_inc(r.wr);
    end
    if (pop) begin
      n.rd = ptr_inc(r.rd);
    end
    if (push && !pop) begin
      n.cnt = CW'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      n.cnt = CW'(r.cnt - 1'b1);
    end
    n.head = n.mem[n.rd];
    n.vld  = (n.cnt != '0);
    n.rdy  = (n.cnt != CW'(DEPTH));
    if (sys_rst) begin
      n     = '0;
      n.rdy = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    r <= n;
  end

  assign in_ready  = r.rdy;
  assign out_data  = r.head;
  assign out_valid = r.vld;

endmodule

// >>> src/ufbp_pkg.sv
package ufbp_pkg;

  // ---------------------------------------------------------------------
  // shared widths and depths
  // ---------------------------------------------------------------------
  localparam int BUS_W     = 8;    // shared byte bus width
  localparam int BUF_DEPTH = 2;    // entries per direction buffer

  // ---------------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------------
  localparam logic PIN_REST  = 1'b1;  // resting level of active-low pins
  localparam logic PIN_ACT   = 1'b0;  // asserted level of active-low pins

  // ---------------------------------------------------------------------
  // read-side sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,   // waiting for read enable to fall
    RX_DRIVE = 2'b01,   // byte on the bus while read enable is low
    RX_DONE  = 2'b10    // byte popped, buffer settles for one cycle
  } ufbp_rx_e;

endpackage

// >>> src/ufbp_port.sv
`timescale 1ns/100ps

// Behaviour
// - eight-bit shared bus carries bytes both ways
// - byte captured on falling write strobe
// - receive flag low while received data held and the read sequencer idle
// - read enable low puts next byte on bus
// - read enable high again releases the bus
// - reset output and configuration-done sense lines
module ufbp_port (
  input  wire logic                       clock,           // 20 MHz clock
  input  wire logic                       sys_rst,         // sync reset
  // host-facing byte streams
  input  wire logic [ufbp_pkg::BUS_W-1:0] host_rx_data,    // byte from host
  input  wire logic                       host_rx_valid,   // byte offered
  output logic                            host_rx_ready,   // room for byte
  output logic      [ufbp_pkg::BUS_W-1:0] host_tx_data,    // byte to host
  output logic                            host_tx_valid,   // byte offered
  input  wire logic                       host_tx_ready,   // host takes it
  // user-logic pins
  output logic                            tx_space_n,      // room, low
  output logic                            rx_avail_n,      // data, low
  input  wire logic                       rd_n,            // read enable
  input  wire logic                       wr,              // write strobe
  input  wire logic [ufbp_pkg::BUS_W-1:0] fifo_bus_in,     // bus level
  output logic      [ufbp_pkg::BUS_W-1:0] fifo_bus_out,    // bus drive
  output logic                            fifo_bus_oe_n,   // drive, low
  // configuration channel lines
  input  wire logic                       cfg_reset_req,   // reset request
  output logic                            target_reset_out,// reset to logic
  input  wire logic                       config_done_sense,// done pin
  output logic                            config_done      // done, sampled
);

  typedef struct packed {
    ufbp_pkg::ufbp_rx_e         st;
    logic                       wr_prev;
    logic                       rx_avail_n;
    logic                       tx_space_n;
    logic [ufbp_pkg::BUS_W-1:0] bus_out;
    logic                       bus_oe_n;
    logic                       tgt_rst;
    logic                       cfg_done;
  } ufbp_port_s;

  ufbp_port_s                 r;
  ufbp_port_s                 n;
  logic                       wr_fall;
  logic                       rx_pop;
  logic [ufbp_pkg::BUS_W-1:0] rxb_data;
  logic                       rxb_valid;
  logic                       txb_ready;

  // ---------------------------------------------------------------------
  // direction buffers
  // ---------------------------------------------------------------------
  // bytes from the host, waiting for the user logic to read them
  ufbp_buf #(
    .WIDTH (ufbp_pkg::BUS_W),
    .DEPTH (ufbp_pkg::BUF_DEPTH)
  ) u_rx_buf (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_data   (host_rx_data),
    .in_valid  (host_rx_valid),
    .in_ready  (host_rx_ready),
    .out_data  (rxb_data),
    .out_valid (rxb_valid),
    .out_ready (rx_pop)
  );

  // bytes written by the user logic, waiting for the host; a stalled
  // host fills it and the space flag then holds the writer off
  ufbp_buf #(
    .WIDTH (ufbp_pkg::BUS_W),
    .DEPTH (ufbp_pkg::BUF_DEPTH)
  ) u_tx_buf (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_data   (fifo_bus_in),
    .in_valid  (wr_fall),
    .in_ready  (txb_ready),
    .out_data  (host_tx_data),
    .out_valid (host_tx_valid),
    .out_ready (host_tx_ready)
  );

  // ---------------------------------------------------------------------
  // pin sequencing
  // ---------------------------------------------------------------------
  // strobe edge and read pop combine registered state with the live wr and rd_n pins
  assign wr_fall = r.wr_prev & ~wr;
  assign rx_pop  = (r.st == ufbp_pkg::RX_DRIVE) && rd_n;

  // next state of all pins and the read sequencer
  always_comb begin
    n          = r;
    n.wr_prev  = wr;
    n.tgt_rst  = cfg_reset_req;
    n.cfg_done = config_done_sense;
    // space flag rises after each write so the writer polls again
    n.tx_space_n = wr_fall | ~txb_ready;
    case (r.st)
      ufbp_pkg::RX_IDLE: begin
        n.rx_avail_n = ~rxb_valid;
        if (!rd_n && rxb_valid) begin
          n.st         = ufbp_pkg::RX_DRIVE;
          n.bus_out    = rxb_data;
          n.bus_oe_n   = ufbp_pkg::PIN_ACT;
          n.rx_avail_n = ufbp_pkg::PIN_REST;
        end
      end
      ufbp_pkg::RX_DRIVE: begin
        n.rx_avail_n = ufbp_pkg::PIN_REST;
        if (rd_n) begin
          n.st       = ufbp_pkg::RX_DONE;
          n.bus_oe_n = ufbp_pkg::PIN_REST;
        end
      end
      ufbp_pkg::RX_DONE: begin
        // buffer head settles before the flag is shown again
        n.rx_avail_n = ufbp_pkg::PIN_REST;
        n.st         = ufbp_pkg::RX_IDLE;
      end
      default: begin
        n.st       = ufbp_pkg::RX_IDLE;
        n.bus_oe_n = ufbp_pkg::PIN_REST;
      end
    endcase
    if (sys_rst) begin
      n            = '0;
      n.st         = ufbp_pkg::RX_IDLE;
      n.wr_prev    = 1'b0;
      n.rx_avail_n = ufbp_pkg::PIN_REST;
      n.tx_space_n = ufbp_pkg::PIN_REST;
      n.bus_oe_n   = ufbp_pkg::PIN_REST;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    r <= n;
  end

  assign tx_space_n       = r.tx_space_n;
  assign rx_avail_n       = r.rx_avail_n;
  assign fifo_bus_out     = r.bus_out;
  assign fifo_bus_oe_n    = r.bus_oe_n;
  assign target_reset_out = r.tgt_rst;
  assign config_done      = r.cfg_done;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_read_drives;
    (r.st == ufbp_pkg::RX_IDLE && !rd_n && rxb_valid)
      |=> (!fifo_bus_oe_n && fifo_bus_out == $past(rxb_data));
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("read enable did not put the byte on the bus");

  property p_release;
    (r.st == ufbp_pkg::RX_DRIVE && rd_n) |=> fifo_bus_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("bus not released after read enable rose");

  property p_drive_needs_rd;
    !fifo_bus_oe_n |-> !$past(rd_n);
  endproperty
  a_drive_needs_rd: assert property (p_drive_needs_rd)
    else $error("bus driven without read enable low");

  property p_bus_stable;
    (!fifo_bus_oe_n && !$past(fifo_bus_oe_n)) |-> $stable(fifo_bus_out);
  endproperty
  a_bus_stable: assert property (p_bus_stable)
    else $error("driven byte changed during a read");

  property p_capture;
    (wr_fall && txb_ready && !host_tx_valid)
      |=> (host_tx_valid && host_tx_data == $past(fifo_bus_in));
  endproperty
  a_capture: assert property (p_capture)
    else $error("byte not captured on falling write strobe");

  property p_avail_true;
    !rx_avail_n |-> rxb_valid;
  endproperty
  a_avail_true: assert property (p_avail_true)
    else $error("receive flag low with no byte held");

  property p_avail_shown;
    (r.st == ufbp_pkg::RX_IDLE && rxb_valid && rd_n) |=> !rx_avail_n;
  endproperty
  a_avail_shown: assert property (p_avail_shown)
    else $error("held byte not flagged");

  property p_space_after_write;
    wr_fall |=> tx_space_n;
  endproperty
  a_space_after_write: assert property (p_space_after_write)
    else $error("space flag not raised after a write");

  property p_cfg_lines;
    ##1 (target_reset_out == $past(cfg_reset_req)
         && config_done == $past(config_done_sense));
  endproperty
  a_cfg_lines: assert property (p_cfg_lines)
    else $error("configuration lines lag wrong");

  c_read: cover property (r.st == ufbp_pkg::RX_DRIVE ##1
                          r.st == ufbp_pkg::RX_DONE);
  c_write: cover property (wr_fall && txb_ready);
  c_tx_full: cover property (!txb_ready && host_tx_valid);

endmodule

// >>> verif/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] host_rx_data = 8'h00;
  logic       host_rx_valid = 1'b0;
  logic       host_rx_ready;
  logic [7:0] host_tx_data;
  logic       host_tx_valid;
  logic       host_tx_ready = 1'b0;
  logic       tx_space_n;
  logic       rx_avail_n;
  logic       rd_n;
  logic       wr;
  logic [7:0] fifo_bus_in;
  logic [7:0] fifo_bus_out;
  logic       fifo_bus_oe_n;
  logic       cfg_reset_req = 1'b0;
  logic       target_reset_out;
  logic       config_done_sense = 1'b0;
  logic       config_done;
  logic [7:0] drv;
  logic       drv_en;
  logic [7:0] idle_pat = 8'h5A;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         cyc = 0;

  always #25 clock = ~clock;

  // an undriven bus flips every cycle so stale bytes never pass
  always @(posedge clock) idle_pat <= ~idle_pat;
  assign fifo_bus_in = !fifo_bus_oe_n ? fifo_bus_out :
                       drv_en ? drv : idle_pat;

  ufbp_port dut (.clock, .sys_rst, .host_rx_data, .host_rx_valid,
    .host_rx_ready, .host_tx_data, .host_tx_valid, .host_tx_ready,
    .tx_space_n, .rx_avail_n, .rd_n, .wr, .fifo_bus_in, .fifo_bus_out,
    .fifo_bus_oe_n, .cfg_reset_req, .target_reset_out,
    .config_done_sense, .config_done);
  ufbp_user u (.clock, .tx_space_n, .rx_avail_n, .bus_lvl(fifo_bus_in),
    .oe_n(fifo_bus_oe_n), .rd_n, .wr, .drv, .drv_en);

  task automatic chk_byte(input string w, input logic [7:0] e,
                          input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk_bit(input string w, input logic e, input logic g);
    chk_byte(w, {7'h00, e}, {7'h00, g});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang costs a mismatch and ends the run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic host_send(input logic [7:0] b);
    @(posedge clock);
    host_rx_data <= b;
    host_rx_valid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (host_rx_ready === 1'b1) break;
    end
    host_rx_valid <= 1'b0;
  endtask

  task automatic host_take(input logic [7:0] e);
    @(posedge clock);
    host_tx_ready <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (host_tx_valid === 1'b1) break;
    end
    host_tx_ready <= 1'b0;
    chk_bit("host_tx_valid", 1'b1, host_tx_valid);
    chk_byte("host_tx_data", e, host_tx_data);
  endtask

  task automatic t_reset();
    chk_bit("rx_avail_n in reset", 1'b1, rx_avail_n);
    chk_bit("fifo_bus_oe_n in reset", 1'b1, fifo_bus_oe_n);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_bit("tx_space_n after reset", 1'b0, tx_space_n);
    $display("reset test done");
  endtask

  task automatic t_config();
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      cfg_reset_req <= ~i[0];
      config_done_sense <= i[0];
      #1;
      chk_bit("target_reset_out early", i[0], target_reset_out);
      @(posedge clock);
      #1;
      chk_bit("target_reset_out", ~i[0], target_reset_out);
      chk_bit("config_done", i[0], config_done);
    end
    $display("config lines test done");
  endtask

  // fill the receive path until refused, then read it all back
  task automatic t_fill_rx();
    logic [7:0] b;
    logic       ok;
    int         n;
    n = 0;
    @(posedge clock);
    host_rx_data <= 8'hA0;
    host_rx_valid <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      if (host_rx_ready === 1'b1) begin
        n++;
        host_rx_data <= 8'hA0 + 8'(n);
      end
    end
    host_rx_valid <= 1'b0;
    chk_bit("host_rx_ready when full", 1'b0, host_rx_ready);
    chk_bit("rx bytes held", 1'b1, n >= ufbp_pkg::BUF_DEPTH);
    for (int i = 0; i < n; i++) begin
      u.fetch(b, ok);
      chk_bit("read flagged", 1'b1, ok);
      chk_byte("read byte", 8'hA0 + 8'(i), b);
      chk_bit("bus released", 1'b1, fifo_bus_oe_n);
    end
    chk_bit("rx_avail_n when empty", 1'b1, rx_avail_n);
    $display("receive fill test done");
  endtask

  // stall the host, write until no room, then drain in order
  task automatic t_fill_tx();
    logic ok;
    int   n;
    n = 0;
    ok = 1'b1;
    while (ok && n < 6) begin
      u.send(8'h50 + 8'(n), ok);
      if (ok) n++;
    end
    chk_bit("tx bytes held", 1'b1, n >= ufbp_pkg::BUF_DEPTH);
    chk_bit("tx_space_n when full", 1'b1, tx_space_n);
    for (int i = 0; i < n; i++) host_take(8'h50 + 8'(i));
    repeat (3) @(posedge clock);
    chk_bit("tx_space_n when drained", 1'b0, tx_space_n);
    chk_bit("host_tx_valid when drained", 1'b0, host_tx_valid);
    $display("transmit fill test done");
  endtask

  // read enable with nothing held must not drive the bus
  task automatic t_refuse();
    u.hold_rd(4);
    chk_bit("bus driven with no data", 1'b1, fifo_bus_oe_n);
    chk_bit("rx_avail_n after refused read", 1'b1, rx_avail_n);
    $display("refused read test done");
  endtask

  // command byte read by user logic and answered back
  task automatic t_echo();
    logic [7:0] b;
    logic       ok;
    host_send(8'h3C);
    u.fetch(b, ok);
    chk_bit("command flagged", 1'b1, ok);
    chk_byte("command byte", 8'h3C, b);
    u.send(~b, ok);
    chk_bit("answer room seen", 1'b1, ok);
    host_take(8'hC3);
    $display("echo test done");
  endtask

  initial begin
    repeat (12) @(posedge clock);
    t_reset();
    t_config();
    t_fill_rx();
    t_fill_tx();
    t_refuse();
    t_echo();
    give_verdict();
  end
endmodule

// >>> verif/ufbp_user.sv
`timescale 1ns/100ps

// ---------------------------------------------------------------------
// user-logic model that polls the port pins
// ---------------------------------------------------------------------
module ufbp_user (
  input  wire logic       clock,      // module clock
  input  wire logic       tx_space_n, // room flag, low
  input  wire logic       rx_avail_n, // data flag, low
  input  wire logic [7:0] bus_lvl,    // shared bus level
  input  wire logic       oe_n,       // port drives bus, low
  output logic            rd_n,       // read enable
  output logic            wr,         // write strobe
  output logic      [7:0] drv,        // byte we drive
  output logic            drv_en      // we drive the bus
);
  logic [1:0] tx_s = 2'b11;
  logic [1:0] rx_s = 2'b11;

  initial begin
    rd_n = 1'b1;
    wr = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  // flags pass two flops, so decisions lag them by two cycles
  always @(posedge clock) begin
    tx_s <= {tx_s[0], tx_space_n};
    rx_s <= {rx_s[0], rx_avail_n};
  end

  // write one byte once room is seen; ok low if it never came
  task automatic send(input logic [7:0] b, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clock);
      ok = (tx_s[1] === 1'b0);
    end
    if (ok) begin
      drv <= b;
      drv_en <= 1'b1;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
      drv_en <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask

  // read one byte once data is flagged
  task automatic fetch(output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clock);
      ok = (rx_s[1] === 1'b0);
    end
    if (ok) begin
      rd_n <= 1'b0;
      for (int i = 0; i < 8 && oe_n !== 1'b0; i++) @(posedge clock);
      ok = (oe_n === 1'b0);
      b = bus_lvl;
      rd_n <= 1'b1;
      repeat (5) @(posedge clock);
    end
  endtask

  // hold read enable low for n cycles regardless of the flag
  task automatic hold_rd(input int n);
    @(posedge clock);
    rd_n <= 1'b0;
    repeat (n) @(posedge clock);
    rd_n <= 1'b1;
  endtask
endmodule
